// >>> common/abam_pkg.sv
// constants for the a-side bus alarm monitor
package abam_pkg;

	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] A_BUS_ALARM_LATCHED_OFF = 8'h22;
	localparam logic [7:0] A_BUS_ALARM_LIVE_OFF    = 8'h23;
	localparam logic [7:0] EXT_CLOCK_H4_LATCHED_OFF = 8'h24;
	localparam logic [7:0] EXT_CLOCK_H4_LIVE_OFF    = 8'h25;
	localparam logic [7:0] B_BUS_ALARM_LATCHED_OFF = 8'h26;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int DROP_CLOCK_LOSS_BIT     = 7;
	localparam int ADD_CLOCK_LOSS_BIT      = 6;
	localparam int DROP_PARITY_ERROR_BIT   = 5;
	localparam int UPSTREAM_AIS_TRIB1_BIT  = 0;
	localparam int EXTERNAL_CLOCK_LOSS_BIT = 7;
	localparam int MULTIFRAME_LOSS_TRIB1_BIT = 0;

	// ---------------------------------------------------------------
	// reset values and codes
	// ---------------------------------------------------------------
	localparam logic [7:0] STATUS_RESET   = 8'h00;
	localparam logic [7:0] AIS_BYTE       = 8'hff;
	localparam logic [1:0] H4_MISS_LIMIT  = 2'h2;
	localparam logic [2:0] H4_RELOCK_GOOD = 3'h4;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int SYS_CLK_KHZ    = 20000;
	localparam int LOC_TIME_NS    = 1000;
	localparam int LOC_TOL_NS     = 500;
	localparam int LOC_CYCLES     = (LOC_TIME_NS * SYS_CLK_KHZ) / 1000000;
	localparam int LOC_CNT_W      = 6;

	// clock index into the loss-of-clock detector array
	localparam int CLK_DROP = 0;
	localparam int CLK_ADD  = 1;
	localparam int CLK_EXT  = 2;

endpackage

// >>> core/abam_monitor.sv
// a-side drop/add bus alarm monitor with live and latched status
// Function
// RULE1: drop clock stuck 1000 ns flags loss
// RULE2: drop timing plus drop loss mutes add
// RULE3: add timing: add clock stuck flags loss
// RULE4: add clock loss mutes add bus outputs
// RULE5: check drop parity every drop clock cycle
// RULE6: parity error only sets status bit
// RULE7: select 0: AIS from H1/H2 per tributary
// RULE8: select 1: AIS from E11/E12/E13 bytes
// RULE9: single-signal format disables AIS 2,3
// RULE10: external clock stuck 1000 ns flags loss
// RULE11: two consecutive H4 mismatches declare loss
// RULE12: H4 phase runs 00,01,10,11 repeating
// RULE13: free run, relock after good sequence
// RULE14: single-signal format disables H4 2,3
// RULE15: H4 loss bits are 1 after reset
// RULE16: latched copy beside each live register
// RULE17: unused status bits read zero
// RULE18: latched bits hold until host read
module abam_monitor #(
	parameter int DATA_W = 8,
	parameter int TRIBS  = 3
) (
	input  wire logic              i_sys_clk,
	input  wire logic              i_reset_n,
	input  wire logic              i_drop_clk,
	input  wire logic              i_add_clk,
	input  wire logic              i_ext_clk,
	input  wire logic [DATA_W-1:0] i_drop_data,
	input  wire logic              i_drop_parity,
	input  wire logic [TRIBS-1:0]  i_ptr_mark,
	input  wire logic [TRIBS-1:0]  i_e1_mark,
	input  wire logic [TRIBS-1:0]  i_h4_mark,
	input  wire logic              i_drop_timing_mode,
	input  wire logic              i_parity_odd,
	input  wire logic              i_ais_source_select,
	input  wire logic              i_h4_detector_select,
	input  wire logic              i_format_single,
	input  wire logic [DATA_W-1:0] i_core_add_data,
	input  wire logic              i_core_add_parity,
	input  wire logic              i_core_add_indicator,
	input  wire logic              i_rd_en,
	input  wire logic [7:0]        i_rd_addr,
	output logic      [7:0]        o_rd_data,
	output logic      [DATA_W-1:0] o_add_data,
	output logic                   o_add_data_oe,
	output logic                   o_add_parity,
	output logic                   o_add_parity_oe,
	output logic                   o_add_indicator
);

	// ---------------------------------------------------------------
	// clock synchronisers and loss-of-clock detectors
	// ---------------------------------------------------------------
	localparam int LOC_CNT_W = abam_pkg::LOC_CNT_W;
	localparam logic [LOC_CNT_W-1:0] LOC_LIMIT = LOC_CNT_W'(abam_pkg::LOC_CYCLES);

	logic [2:0]           clk_s1_q;
	logic [2:0]           clk_s2_q;
	logic [2:0]           clk_s3_q;
	logic [LOC_CNT_W-1:0] loc_cnt_q [3];
	logic [2:0]           loc_q;
	logic [2:0]           clk_edge;
	logic                 drop_rise;

	assign clk_edge  = clk_s2_q ^ clk_s3_q;
	assign drop_rise = clk_s2_q[abam_pkg::CLK_DROP] & ~clk_s3_q[abam_pkg::CLK_DROP];

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			clk_s1_q <= 3'h0;
			clk_s2_q <= 3'h0;
			clk_s3_q <= 3'h0;
		end
		else
		begin
			clk_s1_q <= {i_ext_clk, i_add_clk, i_drop_clk};
			clk_s2_q <= clk_s1_q;
			clk_s3_q <= clk_s2_q;
		end
	end

	// stuck high or low for the limit raises loss; any edge clears it
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			for (int i = 0; i < 3; i++)
				loc_cnt_q[i] <= '0;
			loc_q <= 3'h0;
		end
		else
		begin
			for (int i = 0; i < 3; i++)
			begin
				if (clk_edge[i])
				begin
					loc_cnt_q[i] <= '0;
					loc_q[i]     <= 1'b0; // RULE1 RULE3 RULE10
				end
				else if (loc_cnt_q[i] == LOC_LIMIT - 1'b1)
				begin
					loc_cnt_q[i] <= LOC_LIMIT;
					loc_q[i]     <= 1'b1; // RULE1 RULE3 RULE10
				end
				else if (loc_cnt_q[i] != LOC_LIMIT)
					loc_cnt_q[i] <= loc_cnt_q[i] + 1'b1;
			end
		end
	end

	logic drop_loss;
	logic add_loss;
	logic ext_loss;

	assign drop_loss = loc_q[abam_pkg::CLK_DROP]; // RULE1
	assign add_loss  = loc_q[abam_pkg::CLK_ADD] & ~i_drop_timing_mode; // RULE3
	assign ext_loss  = loc_q[abam_pkg::CLK_EXT]; // RULE10

	// ---------------------------------------------------------------
	// drop bus sampling
	// ---------------------------------------------------------------
	localparam int BUS_W = DATA_W + 1 + 3 * TRIBS;

	logic [BUS_W-1:0]  bus_s1_q;
	logic [BUS_W-1:0]  bus_s2_q;
	logic [DATA_W-1:0] rx_data;
	logic              rx_parity;
	logic [TRIBS-1:0]  rx_ptr;
	logic [TRIBS-1:0]  rx_e1;
	logic [TRIBS-1:0]  rx_h4;

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			bus_s1_q <= '0;
			bus_s2_q <= '0;
		end
		else
		begin
			bus_s1_q <= {i_h4_mark, i_e1_mark, i_ptr_mark, i_drop_parity, i_drop_data};
			bus_s2_q <= bus_s1_q;
		end
	end

	assign {rx_h4, rx_e1, rx_ptr, rx_parity, rx_data} = bus_s2_q;

	// ---------------------------------------------------------------
	// parity check, status only
	// ---------------------------------------------------------------
	logic parity_err_q;

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			parity_err_q <= 1'b0;
		else if (drop_rise)
			parity_err_q <= (^{rx_data, rx_parity}) != i_parity_odd; // RULE5 RULE6
	end

	// ---------------------------------------------------------------
	// upstream ais per tributary
	// ---------------------------------------------------------------
	logic [TRIBS-1:0] ais_q;
	logic [TRIBS-1:0] ais_mark;
	logic [TRIBS-1:0] trib_enable;

	assign ais_mark = i_ais_source_select ? rx_e1 : rx_ptr; // RULE7 RULE8
	// tributaries above the first are off in the single-signal formats
	assign trib_enable = i_format_single ? TRIBS'(1) : {TRIBS{1'b1}}; // RULE9 RULE14

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			ais_q <= '0;
		else
		begin
			for (int t = 0; t < TRIBS; t++)
			begin
				if (!trib_enable[t])
					ais_q[t] <= 1'b0; // RULE9
				else if (drop_rise && ais_mark[t])
					ais_q[t] <= rx_data == abam_pkg::AIS_BYTE; // RULE7 RULE8
			end
		end
	end

	// ---------------------------------------------------------------
	// h4 multiframe detectors
	// ---------------------------------------------------------------
	logic [1:0]       mf_cnt_q  [TRIBS];
	logic [1:0]       mf_miss_q [TRIBS];
	logic [2:0]       mf_good_q [TRIBS];
	logic [TRIBS-1:0] mf_loss_q;
	logic [TRIBS-1:0] mf_report;

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			for (int t = 0; t < TRIBS; t++)
			begin
				mf_cnt_q[t]  <= 2'h0;
				mf_miss_q[t] <= 2'h0;
				mf_good_q[t] <= 3'h0;
			end
			mf_loss_q <= {TRIBS{1'b1}}; // RULE15
		end
		else
		begin
			for (int t = 0; t < TRIBS; t++)
			begin
				if (drop_rise && rx_h4[t])
				begin
					// counter advances 00,01,10,11 every multiframe
					mf_cnt_q[t] <= mf_cnt_q[t] + 2'h1; // RULE12 RULE13
					if (!mf_loss_q[t])
					begin
						if (rx_data[1:0] != mf_cnt_q[t] + 2'h1)
						begin
							mf_miss_q[t] <= mf_miss_q[t] + 2'h1;
							if (mf_miss_q[t] + 2'h1 == abam_pkg::H4_MISS_LIMIT)
							begin
								mf_loss_q[t] <= 1'b1; // RULE11
								mf_good_q[t] <= 3'h0;
								mf_miss_q[t] <= 2'h0;
							end
						end
						else
							mf_miss_q[t] <= 2'h0; // RULE11
					end
					else if (rx_data[1:0] == mf_cnt_q[t] + 2'h1)
					begin
						mf_good_q[t] <= mf_good_q[t] + 3'h1;
						if (mf_good_q[t] + 3'h1 == abam_pkg::H4_RELOCK_GOOD)
						begin
							mf_loss_q[t] <= 1'b0; // RULE13
							mf_good_q[t] <= 3'h0;
						end
					end
					else
					begin
						// take the received phase and start counting again
						mf_cnt_q[t]  <= rx_data[1:0]; // RULE13
						mf_good_q[t] <= 3'h1;
					end
				end
			end
		end
	end

	assign mf_report = mf_loss_q & trib_enable & {TRIBS{~i_h4_detector_select}}; // RULE11 RULE14

	// ---------------------------------------------------------------
	// live and latched status registers
	// ---------------------------------------------------------------
	logic [7:0] a_live;
	logic [7:0] ext_live;
	logic [7:0] a_latched_q;
	logic [7:0] ext_latched_q;
	logic       clr_a;
	logic       clr_ext;

	always_comb
	begin
		a_live = abam_pkg::STATUS_RESET; // RULE17
		a_live[abam_pkg::DROP_CLOCK_LOSS_BIT]   = drop_loss;
		a_live[abam_pkg::ADD_CLOCK_LOSS_BIT]    = add_loss;
		a_live[abam_pkg::DROP_PARITY_ERROR_BIT] = parity_err_q; // RULE5
		a_live[abam_pkg::UPSTREAM_AIS_TRIB1_BIT +: TRIBS] = ais_q;
		ext_live = abam_pkg::STATUS_RESET; // RULE17
		ext_live[abam_pkg::EXTERNAL_CLOCK_LOSS_BIT] = ext_loss;
		ext_live[abam_pkg::MULTIFRAME_LOSS_TRIB1_BIT +: TRIBS] = mf_report;
	end

	assign clr_a   = i_rd_en && (i_rd_addr == abam_pkg::A_BUS_ALARM_LATCHED_OFF);
	assign clr_ext = i_rd_en && (i_rd_addr == abam_pkg::EXT_CLOCK_H4_LATCHED_OFF);

	// a live alarm in the read cycle survives the clear
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			a_latched_q   <= abam_pkg::STATUS_RESET;
			ext_latched_q <= abam_pkg::STATUS_RESET;
		end
		else
		begin
			a_latched_q   <= (clr_a ? 8'h00 : a_latched_q) | a_live; // RULE16 RULE18
			ext_latched_q <= (clr_ext ? 8'h00 : ext_latched_q) | ext_live; // RULE16 RULE18
		end
	end

	// ---------------------------------------------------------------
	// host read port
	// ---------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_rd_data <= 8'h00;
		else if (i_rd_en)
		begin
			case (i_rd_addr)
				abam_pkg::A_BUS_ALARM_LATCHED_OFF:  o_rd_data <= a_latched_q;
				abam_pkg::A_BUS_ALARM_LIVE_OFF:     o_rd_data <= a_live;
				abam_pkg::EXT_CLOCK_H4_LATCHED_OFF: o_rd_data <= ext_latched_q;
				abam_pkg::EXT_CLOCK_H4_LIVE_OFF:    o_rd_data <= ext_live;
				default:                            o_rd_data <= 8'h00; // RULE17
			endcase
		end
	end

	// ---------------------------------------------------------------
	// add bus output gating
	// ---------------------------------------------------------------
	logic add_mute;

	assign add_mute = (i_drop_timing_mode & drop_loss) | add_loss; // RULE2 RULE4

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_add_data      <= '0;
			o_add_data_oe   <= 1'b0;
			o_add_parity    <= 1'b0;
			o_add_parity_oe <= 1'b0;
			o_add_indicator <= 1'b0;
		end
		else
		begin
			o_add_data      <= i_core_add_data;
			o_add_parity    <= i_core_add_parity;
			o_add_data_oe   <= ~add_mute; // RULE2 RULE4
			o_add_parity_oe <= ~add_mute; // RULE2 RULE4
			o_add_indicator <= i_core_add_indicator & ~add_mute; // RULE2 RULE4
		end
	end

endmodule

// >>> tb/abam_props.sv
// assertion checker for the a-side bus alarm monitor
module abam_props #(
	parameter int DATA_W = 8
) (
	input wire logic              i_sys_clk,
	input wire logic              i_reset_n,
	input wire logic              i_drop_clk,
	input wire logic              i_add_clk,
	input wire logic              i_ext_clk,
	input wire logic              i_drop_timing_mode,
	input wire logic [DATA_W-1:0] i_core_add_data,
	input wire logic              i_rd_en,
	input wire logic [7:0]        i_rd_addr,
	input wire logic [7:0]        o_rd_data,
	input wire logic [DATA_W-1:0] o_add_data,
	input wire logic              o_add_data_oe,
	input wire logic              o_add_parity_oe,
	input wire logic              o_add_indicator
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// cycles since each link clock pin last moved
	// ----
	wire logic [2:0] pin = {i_ext_clk, i_add_clk, i_drop_clk};
	logic      [2:0] pin_q;
	logic      [5:0] stuck_q [3];
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			pin_q <= 3'h0;
			stuck_q <= '{default: 6'h00};
		end
		else
		begin
			pin_q <= pin;
			for (int k = 0; k < 3; k++)
				stuck_q[k] <= (pin[k] != pin_q[k]) ? 6'h00 : stuck_q[k] + {5'h00, stuck_q[k] != 6'h3f};
		end
	end
	// ----
	// properties
	// ----
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_reset_n);
	oe_pair_a: assert property (o_add_data_oe == o_add_parity_oe) else $error("add enables split");
	ind_off_a: assert property (!o_add_data_oe |-> !o_add_indicator) else $error("indicator while muted");
	add_copy_a: assert property (o_add_data_oe |-> o_add_data == $past(i_core_add_data)) else $error("add data altered");
	drop_mute_a: assert property (i_drop_timing_mode && stuck_q[0] > 6'h1e |-> !o_add_data_oe) else $error("drop loss no mute");
	add_mute_a: assert property (!i_drop_timing_mode && stuck_q[1] > 6'h1e |-> !o_add_data_oe) else $error("add loss no mute");
	ext_loss_a: assert property (i_rd_en && i_rd_addr == 8'h25 && stuck_q[2] > 6'h1e |=> o_rd_data[7]) else $error("ext loss unseen");
	a_unused_a: assert property (i_rd_en && i_rd_addr inside {8'h22, 8'h23} |=> o_rd_data[4:3] == 2'h0) else $error("a unused set");
	e_unused_a: assert property (i_rd_en && i_rd_addr inside {8'h24, 8'h25} |=> o_rd_data[6:3] == 4'h0) else $error("e unused set");
	cover property (!o_add_data_oe);
	cover property (i_rd_en && i_rd_addr == 8'h22);
	cover property (stuck_q[2] > 6'h1e);
endmodule

bind abam_monitor abam_props #(.DATA_W(DATA_W)) props_u (
	.i_sys_clk, .i_reset_n, .i_drop_clk, .i_add_clk, .i_ext_clk, .i_drop_timing_mode, .i_core_add_data,
	.i_rd_en, .i_rd_addr, .o_rd_data, .o_add_data, .o_add_data_oe, .o_add_parity_oe, .o_add_indicator
);

// >>> tb/abam_bus_model.sv
// behavioural overhead terminator driving the drop bus
module abam_bus_model (
	input  wire logic       i_odd,
	output logic            o_drop_clk,
	output logic      [7:0] o_drop_data,
	output logic            o_drop_parity,
	output logic      [2:0] o_ptr_mark,
	output logic      [2:0] o_e1_mark,
	output logic      [2:0] o_h4_mark
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        run = 1'h1;
	logic [7:0]  fill = 8'h00;
	logic [17:0] q[$];
	logic [17:0] b;
	initial {o_drop_clk, o_drop_data, o_drop_parity, o_ptr_mark, o_e1_mark, o_h4_mark} = '0;
	// clock stands still while run is low
	always #200
		if (run)
			o_drop_clk = ~o_drop_clk;
	// queued byte for one cycle, else a counting filler with good parity
	always @(negedge o_drop_clk)
	begin
		b = {fill, 10'h000};
		if (q.size() != 0)
			b = q.pop_front();
		fill = fill + 8'h01;
		o_drop_data = b[17:10];
		o_drop_parity = ^b[17:10] ^ i_odd ^ b[9];
		{o_ptr_mark, o_e1_mark, o_h4_mark} = b[8:0];
	end
	// f holds bad parity, pointer, e1 and h4 marks
	task automatic put(input logic [7:0] d, input logic [9:0] f);
		q.push_back({d, f});
		wait (q.size() == 0);
		@(negedge o_drop_clk);
	endtask
endmodule

// >>> tb/test_a_side_bus_alarm_monitor.sv
// self-checking bench for the a-side bus alarm monitor
module test_a_side_bus_alarm_monitor;
	timeunit 1ns;
	timeprecision 1ns;
	logic            i_sys_clk = 1'h0;
	logic            i_reset_n = 1'h0;
	logic            i_add_clk = 1'h0;
	logic            i_ext_clk = 1'h0;
	logic            i_drop_timing_mode = 1'h1;
	logic            i_parity_odd = 1'h0;
	logic            i_ais_source_select = 1'h0;
	logic            i_h4_detector_select = 1'h0;
	logic            i_format_single = 1'h0;
	logic      [7:0] i_core_add_data = 8'h5a;
	logic            i_core_add_parity = 1'h1;
	logic            i_core_add_indicator = 1'h1;
	logic            i_rd_en = 1'h0;
	logic      [7:0] i_rd_addr = 8'h00;
	logic            add_run = 1'h1;
	logic            ext_run = 1'h1;
	logic      [2:0] m;
	int              miscompares = 0;
	int              compares = 0;
	wire logic       i_drop_clk;
	wire logic       i_drop_parity;
	wire logic [7:0] i_drop_data;
	wire logic [2:0] i_ptr_mark;
	wire logic [2:0] i_e1_mark;
	wire logic [2:0] i_h4_mark;
	wire logic [7:0] o_rd_data;
	wire logic [7:0] o_add_data;
	wire logic       o_add_data_oe;
	wire logic       o_add_parity;
	wire logic       o_add_parity_oe;
	wire logic       o_add_indicator;

	abam_bus_model model_u (
		.i_odd(i_parity_odd), .o_drop_clk(i_drop_clk), .o_drop_data(i_drop_data), .o_drop_parity(i_drop_parity),
		.o_ptr_mark(i_ptr_mark), .o_e1_mark(i_e1_mark), .o_h4_mark(i_h4_mark)
	);
	abam_monitor dut_u (
		.i_sys_clk, .i_reset_n, .i_drop_clk, .i_add_clk, .i_ext_clk, .i_drop_data, .i_drop_parity,
		.i_ptr_mark, .i_e1_mark, .i_h4_mark, .i_drop_timing_mode, .i_parity_odd, .i_ais_source_select,
		.i_h4_detector_select, .i_format_single, .i_core_add_data, .i_core_add_parity, .i_core_add_indicator,
		.i_rd_en, .i_rd_addr, .o_rd_data, .o_add_data, .o_add_data_oe, .o_add_parity, .o_add_parity_oe,
		.o_add_indicator
	);
	always #25 i_sys_clk = ~i_sys_clk;
	always #200
		if (add_run)
			i_add_clk = ~i_add_clk;
	always #200
		if (ext_run)
			i_ext_clk = ~i_ext_clk;
	// ----
	// access tasks
	// ----
	task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_sys_clk);
		i_rd_en <= 1'h1;
		i_rd_addr <= a;
		@(posedge i_sys_clk);
		i_rd_en <= 1'h0;
		@(posedge i_sys_clk);
		chk($sformatf("reg %h", a), o_rd_data, exp);
	endtask
	task automatic print_verdict;
		if (miscompares == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#500000;
		miscompares++;
		print_verdict();
	end
	// ----
	// tests
	// ----
	initial
	begin
		w(4);
		i_reset_n <= 1'h1;
		w(4);
		rd(8'h25, 8'h07);
		rd(8'h24, 8'h07);
		rd(8'h26, 8'h00);
		rd(8'h22, 8'h00);
		@(posedge i_drop_clk);
		model_u.run = 1'h0;
		w(40);
		chk("add oe", 8'(o_add_data_oe), 8'h00);
		chk("add ind", 8'(o_add_indicator), 8'h00);
		rd(8'h23, 8'h80);
		i_parity_odd <= 1'h1;
		model_u.run = 1'h1;
		w(20);
		rd(8'h23, 8'h00);
		chk("add oe", 8'(o_add_data_oe), 8'h01);
		chk("add ind", 8'(o_add_indicator), 8'h01);
		rd(8'h22, 8'h80);
		rd(8'h22, 8'h00);
		i_drop_timing_mode <= 1'h0;
		add_run = 1'h0;
		w(40);
		chk("add oe", 8'(o_add_data_oe), 8'h00);
		rd(8'h23, 8'h40);
		i_drop_timing_mode <= 1'h1;
		w(2);
		rd(8'h23, 8'h00);
		chk("add oe", 8'(o_add_data_oe), 8'h01);
		add_run = 1'h1;
		w(10);
		rd(8'h22, 8'h40);
		ext_run = 1'h0;
		w(40);
		rd(8'h25, 8'h87);
		ext_run = 1'h1;
		w(10);
		rd(8'h25, 8'h07);
		rd(8'h24, 8'h87);
		i_core_add_data <= 8'ha5;
		i_core_add_parity <= 1'h0;
		model_u.put(8'h3c, 10'h200);
		chk("add data", o_add_data, 8'ha5);
		chk("add par", 8'(o_add_parity), 8'h00);
		chk("add oe", 8'(o_add_data_oe), 8'h01);
		w(12);
		rd(8'h23, 8'h00);
		rd(8'h22, 8'h20);
		rd(8'h22, 8'h00);
		for (int s = 0; s < 4; s++)
		begin
			w(1);
			i_ais_source_select <= s[0];
			i_format_single <= s[1];
			for (int t = 0; t < 3; t++)
			begin
				m = 3'h1 << t;
				model_u.put(8'hff, s[0] ? {1'h0, m, 6'h00} : {4'h0, m, 3'h0});
				w(4);
				rd(8'h23, 8'h00);
				model_u.put(8'hff, s[0] ? {4'h0, m, 3'h0} : {1'h0, m, 6'h00});
				w(4);
				rd(8'h23, (s[1] && t > 0) ? 8'h00 : {5'h00, m});
				model_u.put(8'h00, {1'h0, m, m, 3'h0});
			end
		end
		w(1);
		i_ais_source_select <= 1'h0;
		i_format_single <= 1'h0;
		for (int k = 0; k < 4; k++)
			model_u.put(8'(k), 10'h007);
		w(4);
		rd(8'h25, 8'h00);
		model_u.put(8'h02, 10'h007);
		w(4);
		rd(8'h25, 8'h00);
		model_u.put(8'h03, 10'h007);
		w(4);
		rd(8'h25, 8'h07);
		i_format_single <= 1'h1;
		w(2);
		rd(8'h25, 8'h01);
		i_h4_detector_select <= 1'h1;
		w(2);
		rd(8'h25, 8'h00);
		print_verdict();
	end
endmodule
